// ==== hw/decim_pkg.sv ====
// Constants and types shared by the octal decimation filter
package decim_pkg;
  localparam int CH_COUNT = 8;
  localparam int RES_W = 24;
  localparam int MODE_W = 2;
  // Modulator clock divider
  localparam int DIV_W = 6;
  localparam logic [DIV_W-1:0] DIV_FAST = 6'h04;
  localparam logic [DIV_W-1:0] DIV_LP_HI = 6'h08;
  localparam logic [DIV_W-1:0] DIV_LP_LO = 6'h04;
  localparam logic [DIV_W-1:0] DIV_LS_HI = 6'h28;
  localparam logic [DIV_W-1:0] DIV_LS_LO = 6'h08;
  // Oversampling ratios
  localparam int OSR_W = 7;
  localparam logic [OSR_W-1:0] OSR_HR_LAST = 7'h7f;
  localparam logic [OSR_W-1:0] OSR_STD_LAST = 7'h3f;
  // First stage: sinc cascade at the modulator rate
  localparam int CIC_ORDER = 4;
  localparam int CIC_W = 30;
  localparam int NORM_W = 26;
  localparam int NORM_SHIFT_HR = 5;
  localparam int NORM_SHIFT_STD = 1;
  // Second stage: moving sums at the output rate
  localparam int POST_STAGES = 3;
  localparam int POST_LEN = 24;
  localparam int POST_W = 40;
  localparam int HR_EXTRA_DELAY = 2;
  // Normalisation of the moving sums, 2**29 / 24**3 rounded up
  // Rounding up makes full density land beyond full scale and clip
  localparam int SCALE_W = 18;
  localparam logic signed [SCALE_W-1:0] SCALE_GAIN = 18'sh097b5;
  localparam int SCALE_SHIFT = 29;
  localparam int PROD_W = POST_W + SCALE_W;
  // Output codes
  localparam logic [RES_W-1:0] CODE_POS_FULL = 24'h7fffff;
  localparam logic [RES_W-1:0] CODE_NEG_FULL = 24'h800000;
  localparam int FIFO_DEPTH = 16;

  typedef enum logic [MODE_W-1:0] {
    MODE_HIGH_SPEED = 2'b00,
    MODE_HIGH_RES = 2'b01,
    MODE_LOW_POWER = 2'b10,
    MODE_LOW_SPEED = 2'b11
  } mode_e;
endpackage

// ==== hw/result_fifo.sv ====
// Result FIFO with registered read data
`timescale 1ns/10ps
module result_fifo #(
  parameter int WIDTH = 192,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Fill side
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [WIDTH-1:0] wr_data,
  // Drain side
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [WIDTH-1:0] rd_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic [WIDTH-1:0] rd_data_reg;
  logic rd_valid_reg;
  logic push;
  logic pop;

  assign wr_ready = (count_reg != AW'(0) + (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
  assign push = wr_valid && wr_ready;
  assign pop = (count_reg != '0) && (!rd_valid_reg || rd_ready);
  assign rd_valid = rd_valid_reg;
  assign rd_data = rd_data_reg;

  // Storage
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= wr_data;
    end
  end

  // Pointers and fill level
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + AW'(1);
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + AW'(1);
      end
      count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // Output register
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rd_valid_reg <= 1'b0;
      rd_data_reg <= '0;
    end else if (pop) begin
      rd_valid_reg <= 1'b1;
      rd_data_reg <= mem[rd_ptr_reg];
    end else if (rd_ready) begin
      rd_valid_reg <= 1'b0;
    end
  end
endmodule // result_fifo

// ==== hw/octal_adc_decimation_filter.sv ====
// Eight-channel decimation filter with output formatting
`timescale 1ns/10ps
module octal_adc_decimation_filter (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Operating mode pins
  input wire logic [decim_pkg::MODE_W-1:0] mode_select,
  input wire logic clock_divide_select,
  // Modulator side
  output logic modulator_sample_rate,
  input wire logic [decim_pkg::CH_COUNT-1:0] mod_bits,
  // Result stream
  output logic result_valid,
  input wire logic result_ready,
  output logic [decim_pkg::CH_COUNT*decim_pkg::RES_W-1:0] result_data,
  output logic overrun
);
  import decim_pkg::*;

  localparam int WORD_W = CH_COUNT * RES_W;

  // Divider value for the current mode
  function automatic logic [DIV_W-1:0] div_of(input mode_e m,
                                                input logic sel);
    case (m)
      MODE_HIGH_SPEED: div_of = DIV_FAST;
      MODE_HIGH_RES: div_of = DIV_FAST;
      MODE_LOW_POWER: div_of = sel ? DIV_LP_HI : DIV_LP_LO;
      MODE_LOW_SPEED: div_of = sel ? DIV_LS_HI : DIV_LS_LO;
      default: div_of = DIV_FAST;
    endcase
  endfunction

  // Clip a scaled product to the output code range
  function automatic logic [RES_W-1:0] clip(
      input logic signed [PROD_W-1:0] v);
    // A bare concatenation is unsigned; cast so negatives compare right
    if (v > PROD_W'(signed'(CODE_POS_FULL))) begin
      clip = CODE_POS_FULL;
    end else if (v < signed'({{(PROD_W-RES_W){1'b1}}, CODE_NEG_FULL})) begin
      clip = CODE_NEG_FULL;
    end else begin
      clip = v[RES_W-1:0];
    end
  endfunction

  mode_e mode_reg;
  logic mode_change;
  logic [DIV_W-1:0] div_cnt_reg;
  logic [DIV_W-1:0] div_last;
  logic mod_tick;
  logic mod_clk_reg;
  logic [OSR_W-1:0] phase_reg;
  logic [OSR_W-1:0] phase_last;
  logic out_tick;
  logic post_tick_reg;
  logic scale_tick_reg;
  logic res_tick_reg;
  logic [WORD_W-1:0] res_word;
  logic [WORD_W-1:0] res_d1_reg;
  logic [WORD_W-1:0] res_d2_reg;
  logic [WORD_W-1:0] pend_data_reg;
  logic pend_valid_reg;
  logic fifo_ready;
  logic overrun_reg;

  // mode_select sampled every cycle; clock_divide_select is used unregistered
  // continuous mode watch
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      mode_reg <= MODE_HIGH_SPEED;
    end else begin
      mode_reg <= mode_e'(mode_select);
    end
  end

  assign mode_change = (mode_e'(mode_select) != mode_reg);

  // modulator clock divider
  // Counter restarts on a mode change so the first period is whole
  assign div_last = div_of(mode_reg, clock_divide_select) - DIV_W'(1);
  assign mod_tick = (div_cnt_reg >= div_last);

  always_ff @(posedge sys_clk) begin
    if (sys_rst || mode_change) begin
      div_cnt_reg <= '0;
    end else if (mod_tick) begin
      div_cnt_reg <= '0;
    end else begin
      div_cnt_reg <= div_cnt_reg + DIV_W'(1);
    end
  end

  // Sample clock rises after each tick, high for the first half period
  // Driven from the tick so no short pulse follows reset
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      mod_clk_reg <= 1'b0;
    end else if (mod_tick) begin
      mod_clk_reg <= 1'b1;
    end else if (div_cnt_reg >= (div_last >> 1)) begin
      mod_clk_reg <= 1'b0;
    end
  end

  assign phase_last = (mode_reg == MODE_HIGH_RES) ?
                      OSR_HR_LAST : OSR_STD_LAST;
  assign out_tick = mod_tick && (phase_reg >= phase_last);

  always_ff @(posedge sys_clk) begin
    if (sys_rst || mode_change) begin
      phase_reg <= '0;
    end else if (out_tick) begin
      phase_reg <= '0;
    end else if (mod_tick) begin
      phase_reg <= phase_reg + OSR_W'(1);
    end
  end

  // Pipeline strobes at the output rate
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      post_tick_reg <= 1'b0;
      scale_tick_reg <= 1'b0;
      res_tick_reg <= 1'b0;
    end else begin
      post_tick_reg <= out_tick;
      scale_tick_reg <= post_tick_reg;
      res_tick_reg <= scale_tick_reg;
    end
  end

  // One filter per channel
  genvar ch;
  generate
    for (ch = 0; ch < CH_COUNT; ch++) begin : g_ch
      logic signed [CIC_W-1:0] integ_reg [CIC_ORDER];
      logic signed [CIC_W-1:0] integ_next [CIC_ORDER];
      logic signed [CIC_W-1:0] comb_dly_reg [CIC_ORDER];
      logic signed [CIC_W-1:0] comb_in [CIC_ORDER+1];
      logic signed [NORM_W-1:0] norm_reg;
      logic signed [POST_W-1:0] pint_reg [POST_STAGES];
      logic signed [POST_W-1:0] pint_next [POST_STAGES];
      logic signed [POST_W-1:0] pdly_reg [POST_STAGES][POST_LEN];
      logic signed [POST_W-1:0] pcomb_in [POST_STAGES+1];
      logic signed [POST_W-1:0] post_out_reg;
      logic signed [PROD_W-1:0] prod;
      logic [RES_W-1:0] res_reg;

      always_comb begin
        integ_next[0] = integ_reg[0] +
                        (mod_bits[ch] ? CIC_W'(1) : -CIC_W'(1));
        for (int k = 1; k < CIC_ORDER; k++) begin
          integ_next[k] = integ_reg[k] + integ_next[k-1];
        end
        comb_in[0] = integ_next[CIC_ORDER-1];
        for (int k = 0; k < CIC_ORDER; k++) begin
          comb_in[k+1] = comb_in[k] - comb_dly_reg[k];
        end
      end

      always_ff @(posedge sys_clk) begin
        if (sys_rst || mode_change) begin
          for (int k = 0; k < CIC_ORDER; k++) begin
            integ_reg[k] <= '0;
          end
        end else if (mod_tick) begin
          integ_reg <= integ_next;
        end
      end

      // Decimated differences and normalisation to full scale
      always_ff @(posedge sys_clk) begin
        if (sys_rst || mode_change) begin
          for (int k = 0; k < CIC_ORDER; k++) begin
            comb_dly_reg[k] <= '0;
          end
          norm_reg <= '0;
        end else if (out_tick) begin
          for (int k = 0; k < CIC_ORDER; k++) begin
            comb_dly_reg[k] <= comb_in[k];
          end
          // plus-minus one per bit, zero at half density
          if (mode_reg == MODE_HIGH_RES) begin
            norm_reg <= NORM_W'(comb_in[CIC_ORDER] >>> NORM_SHIFT_HR);
          end else begin
            norm_reg <= NORM_W'(comb_in[CIC_ORDER] >>> NORM_SHIFT_STD);
          end
        end
      end

      always_comb begin
        pint_next[0] = pint_reg[0] + POST_W'(norm_reg);
        for (int k = 1; k < POST_STAGES; k++) begin
          pint_next[k] = pint_reg[k] + pint_next[k-1];
        end
        pcomb_in[0] = pint_next[POST_STAGES-1];
        for (int k = 0; k < POST_STAGES; k++) begin
          pcomb_in[k+1] = pcomb_in[k] - pdly_reg[k][POST_LEN-1];
        end
      end

      always_ff @(posedge sys_clk) begin
        if (sys_rst || mode_change) begin
          for (int k = 0; k < POST_STAGES; k++) begin
            pint_reg[k] <= '0;
            for (int j = 0; j < POST_LEN; j++) begin
              pdly_reg[k][j] <= '0;
            end
          end
          post_out_reg <= '0;
        end else if (post_tick_reg) begin
          pint_reg <= pint_next;
          for (int k = 0; k < POST_STAGES; k++) begin
            pdly_reg[k][0] <= pcomb_in[k];
            for (int j = 1; j < POST_LEN; j++) begin
              pdly_reg[k][j] <= pdly_reg[k][j-1];
            end
          end
          post_out_reg <= pcomb_in[POST_STAGES];
        end
      end

      assign prod = (PROD_W'(post_out_reg) * PROD_W'(SCALE_GAIN))
                    >>> SCALE_SHIFT;

      always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
          res_reg <= '0;
        end else if (scale_tick_reg) begin
          res_reg <= clip(prod);
        end
      end

      assign res_word[ch*RES_W +: RES_W] = res_reg;
    end
  endgenerate

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      res_d1_reg <= '0;
      res_d2_reg <= '0;
    end else if (res_tick_reg) begin
      res_d1_reg <= res_word;
      res_d2_reg <= res_d1_reg;
    end
  end

  // Result waits here while the FIFO is full
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pend_valid_reg <= 1'b0;
      pend_data_reg <= '0;
      overrun_reg <= 1'b0;
    end else begin
      if (res_tick_reg) begin
        pend_valid_reg <= 1'b1;
        // High-Resolution word is two output periods older
        pend_data_reg <= (mode_reg == MODE_HIGH_RES) ?
                         res_d2_reg : res_word;
        overrun_reg <= pend_valid_reg && !fifo_ready;
      end else if (fifo_ready) begin
        pend_valid_reg <= 1'b0;
      end
    end
  end

  result_fifo #(
    .WIDTH(WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .wr_valid(pend_valid_reg),
    .wr_ready(fifo_ready),
    .wr_data(pend_data_reg),
    .rd_valid(result_valid),
    .rd_ready(result_ready),
    .rd_data(result_data)
  );

  assign modulator_sample_rate = mod_clk_reg;
  assign overrun = overrun_reg;
endmodule // octal_adc_decimation_filter

// ==== bench/mod_stream_model.sv ====
// Modulator stream model with a fixed bit density per channel
`timescale 1ns/10ps
module mod_stream_model (
  // Clock and sample clock
  input wire logic sys_clk,
  input wire logic modulator_sample_rate,
  // Density per channel: ones, zeros, otherwise half
  input wire logic [7:0] ones_mask,
  input wire logic [7:0] zeros_mask,
  // Bits to the filter
  output logic [7:0] mod_bits
);
  logic msr_q = 1'b0;
  logic alt = 1'b0;
  // New bit after each sample clock rise, long before the next sampling
  always_ff @(posedge sys_clk) begin
    msr_q <= modulator_sample_rate;
    if (modulator_sample_rate && !msr_q) begin
      alt <= ~alt;
    end
  end
  assign mod_bits = ones_mask | (~zeros_mask & {8{alt}});
endmodule // mod_stream_model

// ==== bench/decim_checker_asserts.sv ====
// Port checker for the octal decimation filter
`timescale 1ns/10ps
module decim_checker (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Mode pins
  input wire logic [decim_pkg::MODE_W-1:0] mode_select,
  input wire logic clock_divide_select,
  // Modulator side
  input wire logic modulator_sample_rate,
  input wire logic [decim_pkg::CH_COUNT-1:0] mod_bits,
  // Result stream
  input wire logic result_valid,
  input wire logic result_ready,
  input wire logic [decim_pkg::CH_COUNT*decim_pkg::RES_W-1:0] result_data,
  input wire logic overrun
);
  import decim_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  logic msr_q, valid_q, pin_q, cfg_ok, win_ok, rise, vrise, cfg_change;
  logic [MODE_W-1:0] mode_q;
  logic [7:0] gap_cnt;
  logic [7:0] tick_cnt;
  assign rise = modulator_sample_rate & ~msr_q;
  assign vrise = result_valid & ~valid_q;
  assign cfg_change = (mode_select != mode_q) |
    (clock_divide_select != pin_q);
  // Cycles between sample clock rises, ticks between results
  always_ff @(posedge sys_clk) begin
    msr_q <= modulator_sample_rate;
    valid_q <= result_valid;
    mode_q <= mode_select;
    pin_q <= clock_divide_select;
    gap_cnt <= rise ? 8'h01 : gap_cnt + 8'h01;
    tick_cnt <= vrise ? {7'h00, rise} : tick_cnt + {7'h00, rise};
  end
  // Windows that saw one steady setting from start to end
  always_ff @(posedge sys_clk) begin
    if (sys_rst || cfg_change) begin
      cfg_ok <= 1'b0;
    end else if (rise) begin
      cfg_ok <= 1'b1;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (sys_rst || cfg_change || !result_ready) begin
      win_ok <= 1'b0;
    end else if (vrise && cfg_ok) begin
      win_ok <= 1'b1;
    end
  end
  sequence s_high_half;
    modulator_sample_rate [*2] ##1 !modulator_sample_rate;
  endsequence
  sequence s_held;
    result_valid && $stable(result_data);
  endsequence
  div_fast_a: assert property (rise && cfg_ok && !mode_select[1]
    |-> gap_cnt == 8'h04) else $error("fast divider wrong");
  div_lp_a: assert property (rise && cfg_ok && mode_select == 2'b10
    |-> gap_cnt == (clock_divide_select ? 8'h08 : 8'h04))
    else $error("low power divider wrong");
  div_ls_a: assert property (rise && cfg_ok && mode_select == 2'b11
    |-> gap_cnt == (clock_divide_select ? 8'h28 : 8'h08))
    else $error("low speed divider wrong");
  high_half_a: assert property (rise && cfg_ok && mode_select == 2'b00
    |-> s_high_half) else $error("sample clock shape wrong");
  ratio_hr_a: assert property (vrise && win_ok && mode_select == 2'b01
    |-> tick_cnt == 8'h80) else $error("ratio not 128");
  ratio_std_a: assert property (vrise && win_ok && mode_select != 2'b01
    |-> tick_cnt == 8'h40) else $error("ratio not 64");
  hold_word_a: assert property (result_valid && !result_ready |=> s_held)
    else $error("result dropped while waiting");
  overrun_full_a: assert property ($rose(overrun) |-> result_valid)
    else $error("overrun without waiting result");
  reset_quiet_a: assert property ($fell(sys_rst)
    |-> !result_valid && !overrun && !modulator_sample_rate)
    else $error("outputs busy after reset");
endmodule // decim_checker

// ==== bench/tb.sv ====
// Testbench for the octal decimation filter
`timescale 1ns/10ps
module tb;
  import decim_pkg::*;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [MODE_W-1:0] mode_select = 2'b00;
  logic clock_divide_select = 1'b1;
  logic modulator_sample_rate;
  logic [CH_COUNT-1:0] mod_bits;
  logic result_valid;
  logic result_ready = 1'b1;
  logic [CH_COUNT*RES_W-1:0] result_data;
  logic [CH_COUNT*RES_W-1:0] word;
  logic overrun;
  logic [7:0] ones_mask = 8'h00;
  logic [7:0] zeros_mask = 8'h00;
  logic msr_q = 1'b0;
  int n_mismatch = 0;
  int tests_run = 0;
  int cycles = 0;
  int ticks = 0;
  int stamp = 0;
  octal_adc_decimation_filter i_octal_adc_decimation_filter (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .mode_select(mode_select),
    .clock_divide_select(clock_divide_select),
    .modulator_sample_rate(modulator_sample_rate), .mod_bits(mod_bits),
    .result_valid(result_valid), .result_ready(result_ready),
    .result_data(result_data), .overrun(overrun));
  mod_stream_model i_mod_stream_model (.sys_clk(sys_clk),
    .modulator_sample_rate(modulator_sample_rate), .ones_mask(ones_mask),
    .zeros_mask(zeros_mask), .mod_bits(mod_bits));
  initial begin
    forever #2.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    msr_q <= modulator_sample_rate;
    if (modulator_sample_rate && !msr_q) begin
      ticks <= ticks + 1;
    end
  end
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 95000) begin
      n_mismatch++;
      $display("timeout after %0d cycles", cycles);
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [RES_W-1:0] seen,
                       input logic [RES_W-1:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic restart(input logic [1:0] m, input logic pin,
                         input logic [7:0] ones, input logic [7:0] zeros);
    @(negedge sys_clk);
    sys_rst = 1'b1;
    mode_select = m;
    clock_divide_select = pin;
    ones_mask = ones;
    zeros_mask = zeros;
    repeat (2) @(negedge sys_clk);
    sys_rst = 1'b0;
  endtask
  task automatic next_word();
    int k;
    k = 0;
    @(negedge sys_clk);
    while (!(result_valid === 1'b1 && result_ready === 1'b1) && k < 12000) begin
      @(negedge sys_clk);
      k++;
    end
    if (k >= 12000) begin
      n_mismatch++;
      $display("timeout waiting for a result word");
    end
    word = result_data;
    stamp = ticks;
    @(posedge sys_clk);
  endtask
  task automatic rates();
    logic [1:0] md [6] = '{2'b00, 2'b01, 2'b10, 2'b10, 2'b11, 2'b11};
    logic pn [6] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
    int dv [6] = '{4, 4, 8, 4, 40, 8};
    int c0;
    int t0;
    for (int i = 0; i < 6; i++) begin
      restart(md[i], pn[i], 8'h00, 8'h00);
      @(posedge modulator_sample_rate);
      c0 = cycles;
      @(posedge modulator_sample_rate);
      check("divider", 24'(cycles - c0), 24'(dv[i]));
      next_word();
      t0 = stamp;
      next_word();
      check("ratio", 24'(stamp - t0),
            md[i] == 2'b01 ? 24'h000080 : 24'h000040);
    end
  endtask
  task automatic stall();
    int k;
    int n;
    k = 0;
    n = 0;
    restart(2'b00, 1'b1, 8'h00, 8'h00);
    result_ready = 1'b0;
    while (overrun !== 1'b1 && k < 6000) begin
      @(negedge sys_clk);
      k++;
    end
    check("overrun", {23'h0, overrun}, 24'h000001);
    result_ready = 1'b1;
    repeat (40) begin
      n += (result_valid === 1'b1) ? 1 : 0;
      @(negedge sys_clk);
    end
    check("drained", 24'(n), 24'(FIFO_DEPTH + 2));
  endtask
  task automatic step(input logic [1:0] m, input int settle);
    restart(m, 1'b1, 8'h01, 8'h02);
    for (int n = 1; n <= 80; n++) begin
      next_word();
      if (n <= 20) begin
        check("early", {23'h0, word[23:20] == 4'h0 || word[23:20] == 4'hf},
              24'h000001);
      end
      if (n > settle) begin
        check("top", word[23:0], 24'h7fffff);
        check("bottom", word[47:24], 24'h800000);
        for (int c = 2; c < CH_COUNT; c++) begin
          check("zero", word[c*RES_W +: RES_W], 24'h000000);
        end
      end
    end
  endtask
  initial begin
    repeat (8) @(posedge sys_clk);
    @(negedge sys_clk);
    sys_rst = 1'b0;
    rates();
    stall();
    step(2'b00, 76);
    step(2'b01, 78);
    tally_and_finish();
  end
endmodule // tb
bind octal_adc_decimation_filter decim_checker i_decim_checker (
  .sys_clk(sys_clk), .sys_rst(sys_rst), .mode_select(mode_select),
  .clock_divide_select(clock_divide_select),
  .modulator_sample_rate(modulator_sample_rate), .mod_bits(mod_bits),
  .result_valid(result_valid), .result_ready(result_ready),
  .result_data(result_data), .overrun(overrun));
